// ===== bench/acc_adc_ctrl_asserts.sv
module acc_adc_ctrl_asserts (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Converter side
   input wire acc_pkg::acc_analog_s analog_out,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic ctrl_wr;
   assign ctrl_wr = psel && penable && pready && pwrite && paddr == acc_pkg::CTRL_ADDR;
   // ----------------------------------------------------------------
   // Bus and control checks
   // ----------------------------------------------------------------
   setup_ready_a: assert property (psel && !penable |=> pready) else $error("pready missing after setup.");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle.");
   err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready.");
   err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("Bad read data.");
   ctrl_read_bits_a: assert property (pready && !pwrite && paddr == acc_pkg::CTRL_ADDR |->
      prdata[31:8] == 24'h0 && !prdata[1]) else $error("Control read shows unused bits.");
   power_follows_a: assert property (ctrl_wr |-> ##2 analog_out.power_on == $past(pwdata[0], 2))
      else $error("Power does not follow the on bit.");
   channel_follows_a: assert property (ctrl_wr && pwdata[0] && pwdata[5:3] <= 3'h4 |-> ##2
      analog_out.channel == $past(pwdata[5:3], 2)) else $error("Channel does not follow the select field.");
   off_no_sample_a: assert property (!analog_out.power_on |-> !analog_out.sample)
      else $error("Sampling while switched off.");
   start_samples_a: assert property (ctrl_wr && pwdata[0] && pwdata[2] && pwdata[5:3] <= 3'h4 |->
      ##[1:40] analog_out.sample) else $error("Start did not begin sampling.");
   cover property (ctrl_wr);
   cover property (pready && pslverr);
   cover property ($rose(irq));
endmodule

// ===== bench/acc_adc_ctrl_tb.sv
module acc_adc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0, rc_tick = 0;
   logic comp_above, pready, pslverr, irq, err, msk, slp;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [39:0] levels = 40'h0;
   logic [1:0] cs;
   logic [2:0] ch;
   logic [5:0] cfg;
   acc_pkg::acc_analog_s analog_out;
   int error_cnt = 0, comparisons = 0, cyc = 0;
   acc_adc_ctrl dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .sleep_mode, .rc_tick, .analog_out, .comp_above, .irq);
   acc_analog_model core (.analog_out, .levels, .comp_above);
   initial forever #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) rc_tick <= ($urandom_range(3) == 0);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task summarize();
      $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         summarize();
      end
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; the wait for pready is bounded only by the cycle ceiling.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function logic [31:0] exp_res(logic [39:0] lv, logic [2:0] c, logic [5:0] pc);
      return pc[c] ? {24'h0, lv[int'(c) * 8 +: 8]} : 32'h0;
   endfunction
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(85850));
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(0, acc_pkg::CTRL_ADDR, 0);
      chk("ctrl reset", rd, 32'h0);
      apb(0, acc_pkg::RESULT_ADDR, 0);
      chk("result reset", rd, 32'h0);
      apb(0, 12'h100, 0);
      chk("unmapped err", err, 1);
      apb(1, acc_pkg::CTRL_ADDR, 32'hFF);
      apb(0, acc_pkg::CTRL_ADDR, 0);
      chk("ctrl fields", rd, 32'hF9);
      apb(1, acc_pkg::CTRL_ADDR, 32'h04);
      apb(0, acc_pkg::CTRL_ADDR, 0);
      chk("start when off", rd, 32'h0);
      for (int i = 0; i < 8; i++) begin
         cs = i[1:0];
         ch = (i == 5) ? 3'h4 : 3'($urandom_range(4));
         cfg = 6'($urandom);
         msk = 1'($urandom);
         slp = i[2];
         levels = {8'($urandom), 32'($urandom)};
         apb(1, acc_pkg::PORTCFG_ADDR, {26'h0, cfg});
         apb(0, acc_pkg::PORTCFG_ADDR, 0);
         chk("port config", rd, {26'h0, cfg});
         chk("analog drive", {analog_out.ext_ref, analog_out.analog_en}, cfg);
         apb(1, acc_pkg::IRQ_MASK_ADDR, {31'h0, msk});
         apb(1, acc_pkg::CTRL_ADDR, {24'h0, cs, ch, 3'b001});
         sleep_mode <= slp;
         apb(1, acc_pkg::CTRL_ADDR, {24'h0, cs, ch, 3'b101});
         if (slp && cs != 2'b11) begin
            repeat (300) @(posedge sys_clk);
            apb(0, acc_pkg::CTRL_ADDR, 0);
            chk("stalled in sleep", rd[2], 1);
            sleep_mode <= 1'b0;
         end
         do apb(0, acc_pkg::CTRL_ADDR, 0); while (rd[2] !== 1'b0);
         sleep_mode <= 1'b0;
         chk("done status", rd, {24'h0, cs, ch, 3'b001});
         apb(0, acc_pkg::RESULT_ADDR, 0);
         chk("result", rd, exp_res(levels, ch, cfg));
         chk("irq raised", irq, msk);
         apb(0, acc_pkg::IRQ_STAT_ADDR, 0);
         chk("irq status set", rd, 1);
         apb(1, acc_pkg::IRQ_STAT_ADDR, 1);
         apb(0, acc_pkg::IRQ_STAT_ADDR, 0);
         chk("irq status cleared", rd, 0);
         chk("irq dropped", irq, 0);
      end
      apb(1, acc_pkg::CTRL_ADDR, 32'h81);
      apb(1, acc_pkg::CTRL_ADDR, 32'h85);
      apb(1, acc_pkg::CTRL_ADDR, 32'h80);
      apb(0, acc_pkg::CTRL_ADDR, 0);
      chk("abort on off", rd, 32'h80);
      apb(1, acc_pkg::CTRL_ADDR, 32'hC5);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      apb(0, acc_pkg::CTRL_ADDR, 0);
      chk("ctrl after reset", rd, 32'h0);
      apb(0, acc_pkg::RESULT_ADDR, 0);
      chk("result after reset", rd, 32'h0);
      apb(0, acc_pkg::PORTCFG_ADDR, 0);
      chk("port config after reset", rd, 32'h0);
      chk("power after reset", analog_out.power_on, 0);
      chk("irq after reset", irq, 0);
      summarize();
   end
endmodule
bind acc_adc_ctrl acc_adc_ctrl_asserts chk_i (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .analog_out, .irq);

// ===== bench/acc_analog_model.sv
module acc_analog_model (
   // Drive from the controller
   input wire acc_pkg::acc_analog_s analog_out,
   // Input levels, one byte per channel
   input wire logic [39:0] levels,
   // Comparator
   output logic comp_above
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lvl;
   // A pin left digital feeds nothing to the hold, so it converts as ground.
   assign lvl = analog_out.analog_en[analog_out.channel] ? levels[analog_out.channel * 8 +: 8] : 8'h00;
   assign comp_above = lvl >= analog_out.trial_code;
endmodule

// ===== hdl/acc_adc_ctrl.sv
// Contract
// - Eight-bit result by successive approximation.
// - Five inputs, pins analog or digital.
// - Reference is supply or reference pin.
// - Sleep conversion only with RC clock.
// - Reset clears registers, aborts conversion.
// - Bits 7-6 select conversion clock.
// - Bits 5-3 select channel 0-4.
// - Writing start bit begins conversion.
// - Hardware clears start bit when done.
// - Bit 0 turns module on, resets 0.
// - Bit 1 reads zero; others read/write.
module acc_adc_ctrl (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // System state
   input wire logic sleep_mode,
   input wire logic rc_tick,
   // Analog core
   output acc_pkg::acc_analog_s analog_out,
   input wire logic comp_above,
   // Interrupt
   output logic irq
);

   logic [7:0] ctrl_q;
   logic [5:0] portcfg_q;
   logic [7:0] result_q;
   logic irq_stat_q;
   logic irq_mask_q;
   logic [4:0] div_cnt_q;
   logic conv_tick_q;
   acc_pkg::acc_state_e state_q;
   logic [3:0] samp_cnt_q;
   logic [7:0] sar_q;
   logic [7:0] bit_q;
   logic done_q;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [1:0] clksel;
   logic conv_tick;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign addr_ok = (paddr == acc_pkg::CTRL_ADDR) || (paddr == acc_pkg::RESULT_ADDR)
      || (paddr == acc_pkg::PORTCFG_ADDR) || (paddr == acc_pkg::IRQ_STAT_ADDR)
      || (paddr == acc_pkg::IRQ_MASK_ADDR);
   assign clksel = ctrl_q[acc_pkg::CLKSEL_LSB +: 2];

   // Single-cycle access: pready rises in the access phase, one cycle after setup.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         unique case (paddr)
            acc_pkg::CTRL_ADDR: prdata <= {24'h000000, ctrl_q & acc_pkg::CTRL_WMASK};
            acc_pkg::RESULT_ADDR: prdata <= {24'h000000, result_q};
            acc_pkg::PORTCFG_ADDR: prdata <= {26'h0000000, portcfg_q};
            acc_pkg::IRQ_STAT_ADDR: prdata <= {31'h00000000, irq_stat_q};
            acc_pkg::IRQ_MASK_ADDR: prdata <= {31'h00000000, irq_mask_q};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   // A start write that leaves the on bit clear is not stored: the start bit is cleared in the same write,
   // so the status bit is held low in that case.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= acc_pkg::CTRL_RESET;
      end else if (wr_en && paddr == acc_pkg::CTRL_ADDR) begin
         ctrl_q <= pwdata[7:0] & acc_pkg::CTRL_WMASK;
         if (!pwdata[acc_pkg::ON_BIT] || pwdata[acc_pkg::CHSEL_LSB +: 3] > 3'h4) begin
            ctrl_q[acc_pkg::START_BIT] <= 1'b0;
         end
         if (done_q) begin
            ctrl_q[acc_pkg::START_BIT] <= 1'b0;
         end
      end else if (done_q || !ctrl_q[acc_pkg::ON_BIT]) begin
         ctrl_q[acc_pkg::START_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         portcfg_q <= acc_pkg::PORTCFG_RESET;
      end else if (wr_en && paddr == acc_pkg::PORTCFG_ADDR) begin
         portcfg_q <= pwdata[5:0];
      end
   end

   // ----------------------------------------------------------------
   // Conversion clock divider
   // ----------------------------------------------------------------
   logic [4:0] div_limit;
   always_comb begin
      unique case (clksel)
         acc_pkg::CLK_DIV2: div_limit = acc_pkg::DIV_FOSC2;
         acc_pkg::CLK_DIV8: div_limit = acc_pkg::DIV_FOSC8;
         acc_pkg::CLK_DIV32: div_limit = acc_pkg::DIV_FOSC32;
         default: div_limit = acc_pkg::DIV_FOSC2;
      endcase
   end

   // The divider stops in sleep because the oscillator it counts is stopped;
   // only the RC tick keeps a conversion moving then.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_q <= 5'h00;
         conv_tick_q <= 1'b0;
      end else if (clksel == acc_pkg::CLK_RC) begin
         div_cnt_q <= 5'h00;
         conv_tick_q <= rc_tick;
      end else if (sleep_mode) begin
         conv_tick_q <= 1'b0;
      end else if (div_cnt_q >= div_limit) begin
         div_cnt_q <= 5'h00;
         conv_tick_q <= 1'b1;
      end else begin
         div_cnt_q <= div_cnt_q + 5'h01;
         conv_tick_q <= 1'b0;
      end
   end
   assign conv_tick = conv_tick_q;

   // ----------------------------------------------------------------
   // Successive approximation sequencer
   // ----------------------------------------------------------------
   // The done cycle blocks a restart, because the start bit is only cleared
   // at the end of that same cycle.
   logic start_req;
   assign start_req = ctrl_q[acc_pkg::START_BIT] && ctrl_q[acc_pkg::ON_BIT] && !done_q;

   // ----------------------------------------------------------------
   // Trial register
   // ----------------------------------------------------------------
   // The comparator answers for the trial code that the core holds now, so the
   // trial register and the code sent to the core must move on the same edge.
   // The core is driven from the next value, which keeps the two equal even
   // when conversion ticks come on back-to-back cycles.
   logic [7:0] sar_d;
   logic [7:0] bit_d;
   logic last_sample;
   assign last_sample = conv_tick && (samp_cnt_q + 4'h1 >= acc_pkg::SAMPLE_TICKS);

   always_comb begin
      sar_d = sar_q;
      bit_d = bit_q;
      if (ctrl_q[acc_pkg::ON_BIT]) begin
         unique case (state_q)
            acc_pkg::ST_SAMPLE: begin
               if (last_sample) begin
                  sar_d = 8'h80;
                  bit_d = 8'h80;
               end
            end
            acc_pkg::ST_CONVERT: begin
               if (conv_tick) begin
                  // Keep the trial bit only while the input is at or above the trial level.
                  if (!comp_above) begin
                     sar_d = (sar_q & ~bit_q) | (bit_q >> 1);
                  end else begin
                     sar_d = sar_q | (bit_q >> 1);
                  end
                  bit_d = bit_q >> 1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sar_q <= 8'h00;
         bit_q <= 8'h00;
      end else begin
         sar_q <= sar_d;
         bit_q <= bit_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= acc_pkg::ST_IDLE;
         samp_cnt_q <= 4'h0;
         done_q <= 1'b0;
      end else if (!ctrl_q[acc_pkg::ON_BIT]) begin
         // Switching off abandons the conversion; the partial code is dropped.
         state_q <= acc_pkg::ST_IDLE;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            acc_pkg::ST_IDLE: begin
               if (start_req) begin
                  state_q <= acc_pkg::ST_SAMPLE;
                  samp_cnt_q <= 4'h0;
               end
            end
            acc_pkg::ST_SAMPLE: begin
               if (last_sample) begin
                  state_q <= acc_pkg::ST_CONVERT;
               end else if (conv_tick) begin
                  samp_cnt_q <= samp_cnt_q + 4'h1;
               end
            end
            acc_pkg::ST_CONVERT: begin
               if (conv_tick && bit_q == 8'h01) begin
                  state_q <= acc_pkg::ST_IDLE;
                  done_q <= 1'b1;
               end
            end
            default: state_q <= acc_pkg::ST_IDLE;
         endcase
      end
   end

   // Result and start-bit clear happen at the same edge, one cycle after the last trial.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= acc_pkg::RESULT_RESET;
      end else if (done_q) begin
         result_q <= sar_q;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= acc_pkg::IRQ_RESET;
      end else if (done_q) begin
         irq_stat_q <= 1'b1;
      end else if (wr_en && paddr == acc_pkg::IRQ_STAT_ADDR && pwdata[0]) begin
         irq_stat_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_q <= acc_pkg::IRQ_RESET;
      end else if (wr_en && paddr == acc_pkg::IRQ_MASK_ADDR) begin
         irq_mask_q <= pwdata[0];
      end
   end

   // Registered so that the pin never glitches while status and mask settle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_stat_q && irq_mask_q;
      end
   end

   // ----------------------------------------------------------------
   // Analog core drive
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         analog_out <= '0;
      end else begin
         analog_out.power_on <= ctrl_q[acc_pkg::ON_BIT];
         analog_out.channel <= ctrl_q[acc_pkg::CHSEL_LSB +: 3];
         // Gated by the on bit so that sampling stops with power_on, one edge after the edge that turns the module off.
         analog_out.sample <= state_q == acc_pkg::ST_SAMPLE && ctrl_q[acc_pkg::ON_BIT];
         analog_out.trial_code <= sar_d;
         analog_out.ext_ref <= portcfg_q[acc_pkg::VREF_SEL_BIT];
         analog_out.analog_en <= portcfg_q[4:0];
      end
   end

endmodule

// ===== hdl/acc_pkg.sv
package acc_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_IDX = 8'h1F;
   localparam logic [11:0] CTRL_ADDR = 12'h07C;
   localparam logic [11:0] RESULT_ADDR = 12'h080;
   localparam logic [11:0] PORTCFG_ADDR = 12'h084;
   localparam logic [11:0] IRQ_STAT_ADDR = 12'h088;
   localparam logic [11:0] IRQ_MASK_ADDR = 12'h08C;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CLKSEL_LSB = 6;
   localparam int CHSEL_LSB = 3;
   localparam int START_BIT = 2;
   localparam int ON_BIT = 0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_WMASK = 8'hFD;

   // Port configuration: bits 4:0 analog enable per pin, bit 5 external reference.
   localparam int VREF_SEL_BIT = 5;
   localparam logic [5:0] PORTCFG_RESET = 6'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [0:0] IRQ_RESET = 1'h0;

   // ----------------------------------------------------------------
   // Conversion timing
   // ----------------------------------------------------------------
   localparam int RES_BITS = 8;
   localparam int NUM_CH = 5;
   localparam logic [4:0] DIV_FOSC2 = 5'h00;
   localparam logic [4:0] DIV_FOSC8 = 5'h03;
   localparam logic [4:0] DIV_FOSC32 = 5'h0F;
   localparam logic [3:0] SAMPLE_TICKS = 4'h2;

   typedef enum logic [1:0] {
      CLK_DIV2 = 2'b00,
      CLK_DIV8 = 2'b01,
      CLK_DIV32 = 2'b10,
      CLK_RC = 2'b11
   } acc_clksel_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10
   } acc_state_e;

   // Drive bundle towards the analog core.
   typedef struct packed {
      logic power_on;
      logic [2:0] channel;
      logic sample;
      logic [7:0] trial_code;
      logic ext_ref;
      logic [4:0] analog_en;
   } acc_analog_s;

endpackage
